// ===== design/pdirc_regs.svh
`ifndef PDIRC_REGS_SVH
`define PDIRC_REGS_SVH

// Clock
`define PDIRC_CLK_NS 10
`define PDIRC_CYC_UP(ns) (((ns) + `PDIRC_CLK_NS - 1) / `PDIRC_CLK_NS)
`define PDIRC_CYC_DN(ns) ((ns) / `PDIRC_CLK_NS)

// Register offsets
`define PDIRC_ADDR_BMC 5'h00
`define PDIRC_ADDR_ICTL 5'h11
`define PDIRC_ADDR_STAT 5'h12
`define PDIRC_ADDR_EDC 5'h1d

// Field positions
`define PDIRC_BMC_RST_BIT 15
`define PDIRC_BMC_PD_BIT 11
`define PDIRC_ICTL_OE_BIT 0
`define PDIRC_ICTL_EN_BIT 1
`define PDIRC_EDC_EN_BIT 15
`define PDIRC_MASK_LINK_BIT 5
`define PDIRC_MASK_ED_BIT 6

// Write masks and reset values
`define PDIRC_BMC_WMASK 16'h7fff
`define PDIRC_ICTL_WMASK 16'h0003
`define PDIRC_BMC_RST 16'h0000
`define PDIRC_ICTL_RST 16'h0000
`define PDIRC_STAT_RST 16'h0000
`define PDIRC_EDC_RST 16'h0000

// Management frame
`define PDIRC_PRE_BITS 6'h20
`define PDIRC_HDR_LAST 5'h0c
`define PDIRC_DATA_LAST 5'h0f
`define PDIRC_OP_RD 2'h2
`define PDIRC_OP_WR 2'h1

// Times in ns
`define PDIRC_POR_NS 1000
`define PDIRC_SWRST_NS 1000
`define PDIRC_ED_IDLE_NS 10000
`define PDIRC_ED_PWRUP_NS 1000
`define PDIRC_ED_PERIOD_NS 1000000
`define PDIRC_ED_PULSE_NS 100

`endif

// ===== design/pdirc_pkg.sv
package pdirc_pkg;

  typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} pdirc_md_state_t;

  typedef enum logic [1:0] {ED_ON, ED_LOW, ED_UP} pdirc_ed_state_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] masks;
  } pdirc_irq_stat_t;

  typedef struct packed {
    logic st;
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] regAddr;
  } pdirc_mdio_hdr_t;

endpackage

// ===== design/pdirc_reset_seq.sv
`timescale 1ns/1ps
`include "pdirc_regs.svh"

module pdirc_reset_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset requests
  input wire logic hwResetN,
  input wire logic swResetReq,
  input wire logic [4:0] strapIn,
  // Results
  output logic coreRst,
  output logic [4:0] strapLatched
);

  localparam logic [7:0] POR_CYC = 8'(`PDIRC_CYC_UP(`PDIRC_POR_NS));
  localparam logic [7:0] SWRST_CYC = 8'(`PDIRC_CYC_DN(`PDIRC_SWRST_NS));

  logic [7:0] cnt, next_cnt;
  logic latchPend, next_latchPend;
  logic next_coreRst;
  logic [4:0] next_strapLatched;

  always_comb begin
    next_cnt = cnt;
    next_latchPend = latchPend;
    next_coreRst = coreRst;
    next_strapLatched = strapLatched;
    if (!hwResetN) begin
      // Pin held low: restart the power-up sequence
      next_cnt = POR_CYC;
      next_latchPend = 1'b1;
      next_coreRst = 1'b1;
    end else if (swResetReq) begin
      next_cnt = SWRST_CYC;
      next_coreRst = 1'b1;
    end else if (cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end else if (coreRst) begin
      next_coreRst = 1'b0;
      if (latchPend) begin
        // Straps only re-latch on power-up or pin reset
        next_strapLatched = strapIn;
        next_latchPend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= POR_CYC;
      latchPend <= 1'b1;
      coreRst <= 1'b1;
      strapLatched <= 5'h00;
    end else begin
      cnt <= next_cnt;
      latchPend <= next_latchPend;
      coreRst <= next_coreRst;
      strapLatched <= next_strapLatched;
    end
  end

endmodule

// ===== design/pdirc_energy_det.sv
`timescale 1ns/1ps
`include "pdirc_regs.svh"

module pdirc_energy_det #(
  parameter int PERIOD_CYC = `PDIRC_CYC_DN(`PDIRC_ED_PERIOD_NS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Control and line
  input wire logic enable,
  input wire logic lineActivity,
  // Status
  output logic lowPower,
  output logic txWake,
  output logic stateChange
);

  localparam int IDLE_CYC = `PDIRC_CYC_UP(`PDIRC_ED_IDLE_NS);
  localparam int PWRUP_CYC = `PDIRC_CYC_UP(`PDIRC_ED_PWRUP_NS);
  localparam int PULSE_CYC = `PDIRC_CYC_UP(`PDIRC_ED_PULSE_NS);

  pdirc_pkg::pdirc_ed_state_t st, next_st;
  logic [16:0] cnt, next_cnt;
  logic next_lowPower, next_txWake, next_stateChange;

  always_comb begin
    next_st = st;
    next_cnt = cnt + 17'h0_0001;
    next_stateChange = 1'b0;
    next_txWake = 1'b0;
    case (st)
      pdirc_pkg::ED_ON: begin
        if (!enable || lineActivity) begin
          next_cnt = 17'h0_0000;
        end else if (cnt == 17'(IDLE_CYC - 1)) begin
          next_st = pdirc_pkg::ED_LOW;
          next_cnt = 17'h0_0000;
          next_stateChange = 1'b1;
        end
      end
      pdirc_pkg::ED_LOW: begin
        if (!enable || lineActivity) begin
          next_st = pdirc_pkg::ED_UP;
          next_cnt = 17'h0_0000;
        end else begin
          if (cnt == 17'(PERIOD_CYC - 1)) begin
            next_cnt = 17'h0_0000;
          end
          // Short burst of line pulses at the start of each period
          next_txWake = cnt < 17'(PULSE_CYC);
        end
      end
      pdirc_pkg::ED_UP: begin
        if (cnt == 17'(PWRUP_CYC - 1)) begin
          next_st = pdirc_pkg::ED_ON;
          next_cnt = 17'h0_0000;
          next_stateChange = 1'b1;
        end
      end
      default: begin
        next_st = pdirc_pkg::ED_ON;
        next_cnt = 17'h0_0000;
      end
    endcase
    next_lowPower = (next_st == pdirc_pkg::ED_LOW);
    if (clr) begin
      next_st = pdirc_pkg::ED_ON;
      next_cnt = 17'h0_0000;
      next_lowPower = 1'b0;
      next_txWake = 1'b0;
      next_stateChange = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= pdirc_pkg::ED_ON;
      cnt <= 17'h0_0000;
      lowPower <= 1'b0;
      txWake <= 1'b0;
      stateChange <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      lowPower <= next_lowPower;
      txWake <= next_txWake;
      stateChange <= next_stateChange;
    end
  end

endmodule

// ===== design/pdirc_top.sv
// What this block does
// - Shared pin is power-down input at reset; control bit 0 makes IRQ out
// - Pin low as input enters power-down, like control power-down bit
// - Weak pull-up is external to logic; pin low at start gives power-down
// - Management access works in power-down; output enable ends pin power-down, not the control bit
// - Sources off at reset; enable bit 1 plus low-byte masks gate the pin
// - Enabled unmasked pending event drives the shared pin low
// - Upper status byte shows one bit per pending source
// - Status read clears pending bits and releases the pin
// - Writes 0003h and 0060h enable link and energy events
// - Energy detect idles low, wakes on activity, pulses periodically
// - Internal power-on reset needs no external reset
// - Pin reset restores defaults and re-latches straps
// - Software reset bit 15 resets, finishing about 1 us later
// - Software reset restores defaults and keeps latched straps
`timescale 1ns/1ps
`include "pdirc_regs.svh"

module pdirc_top #(
  parameter int ED_PERIOD_CYC = `PDIRC_CYC_DN(`PDIRC_ED_PERIOD_NS)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial management
  input wire logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  // Shared power-down and interrupt pin, active low
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  // Reset pin and straps
  input wire logic hwResetN,
  input wire logic [4:0] strapIn,
  // Datapath events and line
  input wire logic [7:0] srcEvent,
  input wire logic lineActivity,
  // Status
  output logic powerDown,
  output logic edLowPower,
  output logic edTxWake,
  output logic [4:0] strapLatched
);

  ////////////////////////////////////////////////////////////////////////////

  logic coreRst;
  logic swRstReq;
  logic edChange;
  logic doWrite;
  logic statusRd;
  logic [15:0] wrData;
  logic [15:0] bmc, next_bmc;
  logic [15:0] ictl, next_ictl;
  logic [15:0] edc, next_edc;
  pdirc_pkg::pdirc_irq_stat_t stat, next_stat;
  logic [7:0] setBits;

  pdirc_reset_seq u_rst (
    .clk(clk),
    .rst(rst),
    .hwResetN(hwResetN),
    .swResetReq(swRstReq),
    .strapIn(strapIn),
    .coreRst(coreRst),
    .strapLatched(strapLatched)
  );

  pdirc_energy_det #(
    .PERIOD_CYC(ED_PERIOD_CYC)
  ) u_ed (
    .clk(clk),
    .rst(rst),
    .clr(coreRst),
    .enable(edc[`PDIRC_EDC_EN_BIT]),
    .lineActivity(lineActivity),
    .lowPower(edLowPower),
    .txWake(edTxWake),
    .stateChange(edChange)
  );

  function automatic logic [15:0] readMux(input logic [4:0] a,
      input logic [15:0] b, input logic [15:0] i,
      input logic [15:0] s, input logic [15:0] e);
    logic [15:0] r;
    r = 16'h0000;
    case (a)
      `PDIRC_ADDR_BMC: r = b;
      `PDIRC_ADDR_ICTL: r = i;
      `PDIRC_ADDR_STAT: r = s;
      `PDIRC_ADDR_EDC: r = e;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Management frame slave; mdc is sampled, data change after its rise

  pdirc_pkg::pdirc_md_state_t mdState, next_mdState;
  logic mdcQ;
  logic mdcRise;
  logic [5:0] preCnt, next_preCnt;
  logic [4:0] bitCnt, next_bitCnt;
  logic [12:0] hdr, next_hdr;
  logic [12:0] hdrIn;
  pdirc_pkg::pdirc_mdio_hdr_t hdrF;
  logic [15:0] shift, next_shift;
  logic isRead, next_isRead;
  logic next_mdioOut, next_mdioOe;

  assign mdcRise = mdc && !mdcQ;

  always_comb begin
    next_mdState = mdState;
    next_preCnt = preCnt;
    next_bitCnt = bitCnt;
    next_hdr = hdr;
    next_shift = shift;
    next_isRead = isRead;
    next_mdioOut = mdioOut;
    next_mdioOe = mdioOe;
    doWrite = 1'b0;
    statusRd = 1'b0;
    wrData = {shift[14:0], mdioIn};
    hdrIn = {hdr[11:0], mdioIn};
    hdrF = pdirc_pkg::pdirc_mdio_hdr_t'(hdrIn);
    if (coreRst) begin
      next_mdState = pdirc_pkg::MD_PRE;
      next_preCnt = 6'h00;
      next_bitCnt = 5'h00;
      next_mdioOut = 1'b0;
      next_mdioOe = 1'b0;
    end else if (mdcRise) begin
      case (mdState)
        pdirc_pkg::MD_PRE: begin
          if (mdioIn) begin
            if (preCnt != `PDIRC_PRE_BITS) begin
              next_preCnt = preCnt + 6'h01;
            end
          end else begin
            next_preCnt = 6'h00;
            if (preCnt == `PDIRC_PRE_BITS) begin
              next_mdState = pdirc_pkg::MD_HDR;
              next_bitCnt = 5'h00;
            end
          end
        end
        pdirc_pkg::MD_HDR: begin
          next_hdr = hdrIn;
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == `PDIRC_HDR_LAST) begin
            next_bitCnt = 5'h00;
            next_mdState = pdirc_pkg::MD_PRE;
            if (hdrF.st && hdrF.phy == strapLatched) begin
              if (hdrF.op == `PDIRC_OP_RD) begin
                next_mdState = pdirc_pkg::MD_TA;
                next_isRead = 1'b1;
                next_shift = readMux(hdrF.regAddr, bmc, ictl, stat, edc);
                statusRd = hdrF.regAddr == `PDIRC_ADDR_STAT;
              end else if (hdrF.op == `PDIRC_OP_WR) begin
                next_mdState = pdirc_pkg::MD_TA;
                next_isRead = 1'b0;
              end
            end
          end
        end
        pdirc_pkg::MD_TA: begin
          next_bitCnt = bitCnt + 5'h01;
          if (bitCnt == 5'h00) begin
            // Second turnaround bit is a driven zero on reads
            next_mdioOe = isRead;
            next_mdioOut = 1'b0;
          end else begin
            next_mdState = pdirc_pkg::MD_DATA;
            next_bitCnt = 5'h00;
            next_mdioOut = isRead && shift[15];
            next_shift = {shift[14:0], 1'b0};
          end
        end
        pdirc_pkg::MD_DATA: begin
          next_bitCnt = bitCnt + 5'h01;
          if (isRead) begin
            next_mdioOut = shift[15];
            next_shift = {shift[14:0], 1'b0};
          end else begin
            next_shift = wrData;
          end
          if (bitCnt == `PDIRC_DATA_LAST) begin
            next_mdState = pdirc_pkg::MD_PRE;
            next_bitCnt = 5'h00;
            next_mdioOe = 1'b0;
            next_mdioOut = 1'b0;
            doWrite = !isRead;
          end
        end
        default: begin
          next_mdState = pdirc_pkg::MD_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdState <= pdirc_pkg::MD_PRE;
      mdcQ <= 1'b0;
      preCnt <= 6'h00;
      bitCnt <= 5'h00;
      hdr <= 13'h0000;
      shift <= 16'h0000;
      isRead <= 1'b0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
    end else begin
      mdState <= next_mdState;
      mdcQ <= mdc;
      preCnt <= next_preCnt;
      bitCnt <= next_bitCnt;
      hdr <= next_hdr;
      shift <= next_shift;
      isRead <= next_isRead;
      mdioOut <= next_mdioOut;
      mdioOe <= next_mdioOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_comb begin
    next_bmc = bmc;
    next_ictl = ictl;
    next_edc = edc;
    next_stat = stat;
    swRstReq = 1'b0;
    setBits = (srcEvent | (8'(edChange) << `PDIRC_MASK_ED_BIT))
        & stat.masks;
    // Set wins: only bits shown by the read are dropped
    next_stat.flags = (stat.flags & ~(statusRd ? stat.flags : 8'h00))
        | setBits;
    if (doWrite) begin
      case (hdr[4:0])
        `PDIRC_ADDR_BMC: begin
          next_bmc = wrData & `PDIRC_BMC_WMASK;
          swRstReq = wrData[`PDIRC_BMC_RST_BIT];
        end
        `PDIRC_ADDR_ICTL: next_ictl = wrData & `PDIRC_ICTL_WMASK;
        `PDIRC_ADDR_STAT: next_stat.masks = wrData[7:0];
        `PDIRC_ADDR_EDC: next_edc = wrData;
        default: next_bmc = bmc;
      endcase
    end
    if (coreRst) begin
      next_bmc = `PDIRC_BMC_RST;
      next_ictl = `PDIRC_ICTL_RST;
      next_stat = `PDIRC_STAT_RST;
      next_edc = `PDIRC_EDC_RST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bmc <= `PDIRC_BMC_RST;
      ictl <= `PDIRC_ICTL_RST;
      stat <= `PDIRC_STAT_RST;
      edc <= `PDIRC_EDC_RST;
    end else begin
      bmc <= next_bmc;
      ictl <= next_ictl;
      stat <= next_stat;
      edc <= next_edc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin and power-down

  logic next_pinOut, next_pinOe, next_powerDown;

  always_comb begin
    next_pinOe = ictl[`PDIRC_ICTL_OE_BIT];
    // Pin is low only with enable set and something pending
    next_pinOut = !(ictl[`PDIRC_ICTL_EN_BIT] && (|stat.flags));
    // Pull-up lives at the pad, so a low here is a real external drive
    next_powerDown = bmc[`PDIRC_BMC_PD_BIT]
        || (!ictl[`PDIRC_ICTL_OE_BIT] && !pinIn);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinOut <= 1'b1;
      pinOe <= 1'b0;
      powerDown <= 1'b0;
    end else begin
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      powerDown <= next_powerDown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_pinMode; !ictl[`PDIRC_ICTL_OE_BIT] |=> !pinOe; endproperty
  a_pinMode: assert property (p_pinMode) else $error("pin not input");
  property p_pdIn; !ictl[`PDIRC_ICTL_OE_BIT] && !pinIn |=> powerDown;
  endproperty
  a_pdIn: assert property (p_pdIn) else $error("no power-down");
  property p_pdExit;
    ictl[`PDIRC_ICTL_OE_BIT] && !bmc[`PDIRC_BMC_PD_BIT] |=> !powerDown;
  endproperty
  a_pdExit: assert property (p_pdExit) else $error("stuck down");
  property p_rstOff; coreRst |=> stat.masks == 8'h00 && ictl == 16'h0000;
  endproperty
  a_rstOff: assert property (p_rstOff) else $error("not cleared");
  property p_assert;
    ictl[`PDIRC_ICTL_EN_BIT] && (|stat.flags) |=> !pinOut;
  endproperty
  a_assert: assert property (p_assert) else $error("pin not low");
  property p_clear; statusRd && setBits == 8'h00 && !coreRst
      |=> stat.flags == 8'h00 ##1 pinOut; endproperty
  a_clear: assert property (p_clear) else $error("read kept flags");
  property p_keep; statusRd && !coreRst
      |=> stat.flags == $past(setBits); endproperty
  a_keep: assert property (p_keep) else $error("event lost");
  property p_off; !ictl[`PDIRC_ICTL_EN_BIT] |=> pinOut; endproperty
  a_off: assert property (p_off) else $error("pin low, disabled");
  property p_swRst; swRstReq |=> coreRst [*8]; endproperty
  a_swRst: assert property (p_swRst) else $error("short reset");
  property p_straps; swRstReq |=> $stable(strapLatched) [*8]; endproperty
  a_straps: assert property (p_straps) else $error("straps moved");

endmodule

// ===== tb/pdirc_host.sv
`timescale 1ns/1ps
`include "pdirc_regs.svh"

module pdirc_host (
  // Clock
  input wire logic clk,
  // Management lines
  input wire logic mdioLine,
  output logic mdc,
  output logic mdioDrv,
  output logic mdioHostOe,
  output logic hdrDone,
  // Reset pin, active low
  output logic hwResetN
);
  // Extra low cycles per management bit, to act as a slow host
  int slow = 0;

  initial begin
    mdc = 1'b0;
    mdioDrv = 1'b1;
    mdioHostOe = 1'b0;
    hdrDone = 1'b0;
    hwResetN = 1'b1;
  end

  ////////////////////////////////////////
  // Sampled as mdc rises, before the device can react to that edge
  task automatic mbit(input logic d, input logic oe, output logic q);
    @(negedge clk);
    mdc = 1'b0;
    mdioDrv = d;
    mdioHostOe = oe;
    repeat (3 + slow) @(negedge clk);
    mdc = 1'b1;
    q = mdioLine;
    repeat (2) @(negedge clk);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic q;
    hdr = {2'b01, op, phy, ra};
    tail = {2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, q);
    for (int i = 13; i >= 0; i--) begin
      hdrDone = (i == 0);
      mbit(hdr[i], 1'b1, q);
    end
    // A read hands the line over for turnaround and data
    for (int i = 17; i >= 0; i--) begin
      mbit(tail[i], op == `PDIRC_OP_WR, q);
      if (i < 16) rd[i] = q;
    end
    hdrDone = 1'b0;
    mbit(1'b1, 1'b0, q);
  endtask

  task automatic pinReset();
    @(negedge clk);
    hwResetN = 1'b0;
    repeat (`PDIRC_CYC_UP(1000)) @(negedge clk);
    hwResetN = 1'b1;
    repeat (`PDIRC_CYC_UP(3000)) @(negedge clk);
  endtask

  task automatic swWait();
    repeat (`PDIRC_CYC_UP(3000)) @(negedge clk);
  endtask
endmodule

// ===== tb/pdirc_top_tb.sv
`timescale 1ns/1ps
`include "pdirc_regs.svh"

`define CHK(nm, ex, sn) begin \
  checked++; \
  if ((sn) !== (ex)) begin \
    failCount++; \
    $display("unexpected %s exp %h seen %h", nm, ex, sn); \
  end \
end

module pdirc_top_tb;
  localparam int PER = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mdc, mdioDrv, mdioHostOe, hdrDone, mdioOut, mdioOe, mdioLine;
  logic pinOut, pinOe, pinLine, hwResetN;
  logic pullDown = 1'b0;
  logic lineActivity = 1'b1;
  logic [7:0] srcEvent = 8'h00;
  logic [4:0] strapIn, strapLatched, phy;
  logic powerDown, edLowPower, edTxWake;
  logic [15:0] rd;
  logic [4:0] adr [5] = '{`PDIRC_ADDR_BMC, `PDIRC_ADDR_ICTL,
    `PDIRC_ADDR_STAT, `PDIRC_ADDR_EDC, 5'h05};
  int failCount = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 32'h21a8_ab1b;
  int flg = 0;
  int msk = 0;
  int n;

  always #5 clk = ~clk;
  // Both shared lines float high through weak pull-ups
  assign mdioLine = mdioOe ? mdioOut : (mdioHostOe ? mdioDrv : 1'b1);
  assign pinLine = pinOe ? pinOut : !pullDown;

  pdirc_host host (.clk(clk), .mdioLine(mdioLine), .mdc(mdc),
    .mdioDrv(mdioDrv), .mdioHostOe(mdioHostOe), .hdrDone(hdrDone),
    .hwResetN(hwResetN));

  pdirc_top #(.ED_PERIOD_CYC(PER)) dut (.clk(clk), .rst(rst), .mdc(mdc),
    .mdioIn(mdioLine), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .pinIn(pinLine), .pinOut(pinOut), .pinOe(pinOe),
    .hwResetN(hwResetN), .strapIn(strapIn), .srcEvent(srcEvent),
    .lineActivity(lineActivity), .powerDown(powerDown),
    .edLowPower(edLowPower), .edTxWake(edTxWake),
    .strapLatched(strapLatched));

  ////////////////////////////////////////
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failCount++;
      $display("timeout");
      completeRun();
    end
  end

  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    host.frame(`PDIRC_OP_WR, phy, ra, d, rd);
  endtask

  task automatic rdChk(input logic [4:0] ra, input logic [15:0] ex);
    host.frame(`PDIRC_OP_RD, phy, ra, 16'h0000, rd);
    `CHK("register", ex, rd)
  endtask

  // Reading status empties the model's pending set as well
  task automatic rdStat();
    rdChk(`PDIRC_ADDR_STAT, 16'(flg | msk));
    flg = 0;
  endtask

  task automatic fire(input logic [7:0] ev, input int cycles);
    srcEvent = ev;
    flg = flg | ((int'(ev) & msk) << 8);
    repeat (cycles) @(negedge clk);
    srcEvent = 8'h00;
  endtask

  ////////////////////////////////////////
  initial begin
    strapIn = 5'($random(seed));
    phy = strapIn;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (150) @(negedge clk);
    `CHK("pinOe", 1'b0, pinOe)
    `CHK("pinOut", 1'b1, pinOut)
    `CHK("strap", phy, strapLatched)
    for (int i = 0; i < 5; i++) rdChk(adr[i], 16'h0000);
    $display("test defaults done");
    pullDown = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("powerDown", 1'b1, powerDown)
    host.slow = 4;
    rdChk(`PDIRC_ADDR_ICTL, 16'h0000);
    host.slow = 0;
    wr(`PDIRC_ADDR_ICTL, 16'h0001);
    `CHK("powerDown", 1'b0, powerDown)
    `CHK("pinOe", 1'b1, pinOe)
    pullDown = 1'b0;
    wr(`PDIRC_ADDR_BMC, 16'h0800);
    `CHK("powerDown", 1'b1, powerDown)
    rdChk(`PDIRC_ADDR_BMC, 16'h0800);
    wr(`PDIRC_ADDR_BMC, 16'h0000);
    $display("test power down done");
    wr(`PDIRC_ADDR_STAT, 16'h0060);
    msk = 'h60;
    fire(8'h60, 1);
    repeat (3) @(negedge clk);
    `CHK("pinOut", 1'b1, pinOut)
    rdStat();
    rdStat();
    wr(`PDIRC_ADDR_ICTL, 16'h0003);
    for (int i = 0; i < 6; i++) begin
      msk = $random(seed) & 'hff;
      wr(`PDIRC_ADDR_STAT, 16'(msk));
      fire(8'($random(seed)), 1);
      repeat (2) @(negedge clk);
      `CHK("pinOut", flg == 0, pinOut)
      rdStat();
      repeat (3) @(negedge clk);
      `CHK("pinOut", 1'b1, pinOut)
    end
    wr(`PDIRC_ADDR_STAT, 16'h0020);
    msk = 'h20;
    // Events straddle the clearing read; the later ones must survive
    fork
      host.frame(`PDIRC_OP_RD, phy, `PDIRC_ADDR_STAT, 16'h0000, rd);
      begin
        @(posedge hdrDone);
        fire(8'h20, 8);
      end
    join
    flg = 'h2000;
    `CHK("pinOut", 1'b0, pinOut)
    rdStat();
    $display("test interrupts done");
    wr(`PDIRC_ADDR_EDC, 16'h0234);
    strapIn = ~phy;
    wr(`PDIRC_ADDR_BMC, 16'h8800);
    repeat (115) @(negedge clk);
    `CHK("powerDown", 1'b0, powerDown)
    host.swWait();
    msk = 0;
    `CHK("strap", phy, strapLatched)
    `CHK("pinOe", 1'b0, pinOe)
    for (int i = 0; i < 4; i++) rdChk(adr[i], 16'h0000);
    wr(`PDIRC_ADDR_ICTL, 16'h0001);
    host.pinReset();
    phy = strapIn;
    `CHK("strap", phy, strapLatched)
    `CHK("pinOe", 1'b0, pinOe)
    rdChk(`PDIRC_ADDR_ICTL, 16'h0000);
    $display("test resets done");
    wr(`PDIRC_ADDR_STAT, 16'h0040);
    msk = 'h40;
    wr(`PDIRC_ADDR_ICTL, 16'h0003);
    wr(`PDIRC_ADDR_EDC, 16'h8000);
    lineActivity = 1'b0;
    n = 0;
    while (edLowPower !== 1'b1 && n < 1200) begin
      @(negedge clk);
      n++;
    end
    flg = 'h4000;
    `CHK("idle", 1'b1, n > 990 && n < 1010)
    // State change sets the flag one edge later, the pin one edge after
    repeat (2) @(negedge clk);
    `CHK("pinOut", 1'b0, pinOut)
    n = 0;
    repeat (2 * PER) begin
      @(negedge clk);
      n += int'(edTxWake === 1'b1);
    end
    `CHK("wake", 16'(2 * `PDIRC_CYC_DN(`PDIRC_ED_PULSE_NS)), 16'(n))
    lineActivity = 1'b1;
    repeat (`PDIRC_CYC_UP(`PDIRC_ED_PWRUP_NS) + 10) @(negedge clk);
    `CHK("edLowPower", 1'b0, edLowPower)
    rdStat();
    $display("test energy detect done");
    completeRun();
  end
endmodule
